// ### core/flow_pkg.sv
// Purpose: Shared types and constants of the program-flow and stack unit.
// Assumes: One core clock; commands come from the instruction decoder.
// Notes: The call stack frame is byte0 = {carry, zero, ip[13:8]}, byte1 = ip[7:0].
`default_nettype none
package flow_pkg;
   // ===========================================================
   // Widths and reset values
   localparam int IP_W = 14;
   localparam int PAGE_W = 6;
   localparam int BYTE_W = 8;
   localparam int MEM_DEPTH = 256;
   localparam logic [13:0] IP_RST = 14'h0000;
   localparam logic [7:0] CSP_RST = 8'h00;
   localparam logic [7:0] OSP_RST = 8'h00;
   localparam logic [7:0] BYTE_ONE = 8'h01;
   localparam logic [5:0] PAGE_ONE = 6'h01;
   // ===========================================================
   // Frame byte 0 field positions
   localparam int FR_CARRY = 7;
   localparam int FR_ZERO = 6;

   // Operations that the decoder hands over.
   typedef enum logic [3:0] {
      OP_SEQ, OP_PAGE, OP_CALL, OP_RET, OP_INT_ACK, OP_INT_RET,
      OP_PUSH, OP_POP, OP_LOAD_CSP, OP_LOAD_ACC, OP_LOAD_OFS, OP_STORE_ACC
   } op_t;

   // Operand addressing modes.
   typedef enum logic [1:0] {AM_IMM, AM_DIRECT, AM_INDEXED} amode_t;

   // One decoded command.
   typedef struct packed {
      op_t op;            // Operation.
      logic [1:0] len;    // Instruction length in bytes, 1 or 2.
      amode_t mode;       // Operand addressing mode.
      logic [7:0] operand; // Second instruction byte.
      logic [13:0] target; // Call target or interrupt vector.
      logic flag_we;      // Load carry and zero from the ALU.
      logic carry;        // ALU carry.
      logic zero;         // ALU zero.
   } cmd_t;
endpackage
`default_nettype wire

// ### core/flow_unit.sv
// Purpose: Instruction pointer, call stack, operand stack and operand addressing.
// Assumes: One command per accepted cycle while busy_r is low.
// Notes: Data memory is held here as 256 bytes of flip-flops.
// Contract
// - Instruction pointer is 14 bits and clears to zero on reset.
// - Only the low 8 bits advance with fetched instruction bytes.
// - Upper 6 bits increment only on the page advance instruction.
// - Instructions are one or two bytes; pointer advances by the length.
// - Interrupt acknowledge and CALL save next address plus carry and zero.
// - RET restores the pointer, not the flags; call stack pointer drops two.
// - No firmware path to the pointer; call stack readable from 0x00.
// - Call stack pointer is 8 bits, resets to zero, grows upward.
// - Firmware may load the call stack pointer from the accumulator.
// - Interrupt entry disables interrupts, writes byte, increments, writes, increments.
// - Interrupt return decrements, restores second, decrements, restores first, enables.
// - CALL pushes the frame and leaves the pointer two higher.
// - PUSH pre-decrements the operand stack pointer then writes.
// - POP reads at the operand stack pointer then post-increments.
// - Operand stack pointer resets to zero; first push writes 0xFF.
// - Immediate mode uses the second instruction byte as a constant.
// - Direct mode uses the one-byte address in the instruction.
// - Indexed mode adds the instruction constant to the offset register.
// - Operand stack pointer, accumulator and offset are all 8 bits.
// - Data memory holds 256 bytes shared by stacks and variables.
`timescale 1ns/1ps
`default_nettype none
module flow_unit (
   input wire logic mclk,                  // Core clock, 100 MHz.
   input wire logic rst,                   // Synchronous reset, active high.
   input wire logic cmd_valid,             // Command offered.
   input wire flow_pkg::cmd_t cmd,         // Decoded command.
   input wire logic [7:0] rd_addr,         // Data memory inspect address.
   output logic [7:0] rd_data_r,           // Data memory byte at rd_addr.
   output logic [13:0] ip_r,               // Instruction pointer.
   output logic [7:0] csp_r,               // Call stack pointer.
   output logic [7:0] osp_r,               // Operand stack pointer.
   output logic [7:0] acc_r,               // Accumulator.
   output logic [7:0] ofs_r,               // Offset register.
   output logic carry_r,                   // Carry flag.
   output logic zero_r,                    // Zero flag.
   output logic int_en_r,                  // Interrupts enabled.
   output logic busy_r,                    // Frame transfer in progress.
   output logic done_r                     // Command finished, one cycle.
);
   // ===========================================================
   // Declarations
   typedef enum logic [1:0] {ST_IDLE, ST_WR2, ST_RD2, ST_RD1} state_t;
   state_t state_r, state_nxt;
   logic [13:0] ip_nxt, ret_ip_r, ret_ip_nxt;
   logic [7:0] csp_nxt, osp_nxt, acc_nxt, ofs_nxt; // All one byte wide.
   logic carry_nxt, zero_nxt, int_en_nxt, busy_nxt, done_nxt, interrupt_return_r, interrupt_return_nxt;
   logic [7:0] mem [flow_pkg::MEM_DEPTH];
   logic mem_we;
   logic [7:0] mem_wa, mem_wd, eff_addr, rd_val, osp_dec;
   logic accept;

   // Next address within the page; the low byte wraps without carry.
   function automatic logic [13:0] advance(input logic [13:0] ip, input logic [1:0] len);
      advance = {ip[13:8], ip[7:0] + {6'h00, len}};
   endfunction

   // Operand address for direct and indexed modes.
   function automatic logic [7:0] addr_of(input flow_pkg::amode_t m, input logic [7:0] k,
                                          input logic [7:0] ofs);
      addr_of = (m == flow_pkg::AM_INDEXED) ? k + ofs : k;
   endfunction

   assign accept = cmd_valid && !busy_r;
   assign eff_addr = addr_of(cmd.mode, cmd.operand, ofs_r);
   assign rd_val = (cmd.mode == flow_pkg::AM_IMM) ? cmd.operand : mem[eff_addr];
   assign osp_dec = osp_r - flow_pkg::BYTE_ONE;

   // ===========================================================
   // Next-state logic for pointers, registers and frame sequencing
   always_comb begin
      state_nxt = state_r;
      ip_nxt = ip_r;
      ret_ip_nxt = ret_ip_r;
      interrupt_return_nxt = interrupt_return_r;
      csp_nxt = csp_r;
      osp_nxt = osp_r;
      acc_nxt = acc_r;
      ofs_nxt = ofs_r;
      carry_nxt = carry_r;
      zero_nxt = zero_r;
      int_en_nxt = int_en_r;
      done_nxt = 1'b0;
      mem_we = 1'b0;
      mem_wa = csp_r;
      mem_wd = 8'h00;
      unique case (state_r)
         ST_IDLE: begin
            if (accept) begin
               unique case (cmd.op)
                  flow_pkg::OP_SEQ: begin
                     ip_nxt = advance(ip_r, cmd.len);
                     if (cmd.flag_we) begin
                        carry_nxt = cmd.carry;
                        zero_nxt = cmd.zero;
                     end
                     done_nxt = 1'b1;
                  end
                  flow_pkg::OP_PAGE: begin
                     // Page advance bumps the upper field; the low byte moves on by one.
                     ip_nxt = {ip_r[13:8] + flow_pkg::PAGE_ONE, ip_r[7:0] + 8'h01};
                     done_nxt = 1'b1;
                  end
                  flow_pkg::OP_CALL, flow_pkg::OP_INT_ACK: begin
                     // First frame byte at the pointer, then increment.
                     ret_ip_nxt = (cmd.op == flow_pkg::OP_CALL) ? advance(ip_r, cmd.len)
                                                                : ip_r;
                     mem_we = 1'b1;
                     mem_wd = {carry_r, zero_r, ret_ip_nxt[13:8]};
                     csp_nxt = csp_r + flow_pkg::BYTE_ONE;
                     if (cmd.op == flow_pkg::OP_INT_ACK) begin
                        int_en_nxt = 1'b0;
                     end
                     ip_nxt = cmd.target;
                     state_nxt = ST_WR2;
                  end
                  flow_pkg::OP_RET, flow_pkg::OP_INT_RET: begin
                     interrupt_return_nxt = (cmd.op == flow_pkg::OP_INT_RET);
                     csp_nxt = csp_r - flow_pkg::BYTE_ONE;
                     state_nxt = ST_RD2;
                  end
                  flow_pkg::OP_PUSH: begin
                     osp_nxt = osp_dec;
                     mem_we = 1'b1;
                     mem_wa = osp_dec;
                     mem_wd = acc_r;
                     ip_nxt = advance(ip_r, 2'd1);
                     done_nxt = 1'b1;
                  end
                  flow_pkg::OP_POP: begin
                     acc_nxt = mem[osp_r];
                     osp_nxt = osp_r + flow_pkg::BYTE_ONE;
                     ip_nxt = advance(ip_r, 2'd1);
                     done_nxt = 1'b1;
                  end
                  flow_pkg::OP_LOAD_CSP: begin
                     csp_nxt = acc_r;
                     ip_nxt = advance(ip_r, 2'd1);
                     done_nxt = 1'b1;
                  end
                  flow_pkg::OP_LOAD_ACC, flow_pkg::OP_LOAD_OFS: begin
                     if (cmd.op == flow_pkg::OP_LOAD_ACC) begin
                        acc_nxt = rd_val;
                     end else begin
                        ofs_nxt = rd_val;
                     end
                     ip_nxt = advance(ip_r, cmd.len);
                     done_nxt = 1'b1;
                  end
                  flow_pkg::OP_STORE_ACC: begin
                     mem_we = 1'b1;
                     mem_wa = eff_addr;
                     mem_wd = acc_r;
                     ip_nxt = advance(ip_r, cmd.len);
                     done_nxt = 1'b1;
                  end
                  default: begin
                     done_nxt = 1'b1;
                  end
               endcase
            end
         end
         ST_WR2: begin
            // Second frame byte at the new pointer, then increment again.
            mem_we = 1'b1;
            mem_wd = ret_ip_r[7:0];
            csp_nxt = csp_r + flow_pkg::BYTE_ONE;
            done_nxt = 1'b1;
            state_nxt = ST_IDLE;
         end
         ST_RD2: begin
            // Second byte back, then step down to the first.
            ip_nxt = {ip_r[13:8], mem[csp_r]};
            csp_nxt = csp_r - flow_pkg::BYTE_ONE;
            state_nxt = ST_RD1;
         end
         ST_RD1: begin
            ip_nxt = {mem[csp_r][5:0], ip_r[7:0]};
            if (interrupt_return_r) begin
               carry_nxt = mem[csp_r][flow_pkg::FR_CARRY];
               zero_nxt = mem[csp_r][flow_pkg::FR_ZERO];
               int_en_nxt = 1'b1;
            end
            done_nxt = 1'b1;
            state_nxt = ST_IDLE;
         end
      endcase
      busy_nxt = (state_nxt != ST_IDLE);
   end

   // Register stage for the control group.
   always_ff @(posedge mclk) begin
      if (rst) begin
         state_r <= ST_IDLE;
         ip_r <= flow_pkg::IP_RST;
         ret_ip_r <= flow_pkg::IP_RST;
         interrupt_return_r <= 1'b0;
         csp_r <= flow_pkg::CSP_RST;
         osp_r <= flow_pkg::OSP_RST;
         acc_r <= 8'h00;
         ofs_r <= 8'h00;
         carry_r <= 1'b0;
         zero_r <= 1'b0;
         int_en_r <= 1'b0;
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         ip_r <= ip_nxt;
         ret_ip_r <= ret_ip_nxt;
         interrupt_return_r <= interrupt_return_nxt;
         csp_r <= csp_nxt;
         osp_r <= osp_nxt;
         acc_r <= acc_nxt;
         ofs_r <= ofs_nxt;
         carry_r <= carry_nxt;
         zero_r <= zero_nxt;
         int_en_r <= int_en_nxt;
         busy_r <= busy_nxt;
         done_r <= done_nxt;
      end
   end

   // Data memory store and the inspect read port.
   always_ff @(posedge mclk) begin
      if (mem_we) begin
         mem[mem_wa] <= mem_wd;
      end
      rd_data_r <= rst ? 8'h00 : mem[rd_addr];
   end

   // ===========================================================
   // Checks
   logic [13:0] adv_ip;
   logic [7:0] osp_byte;
   logic [7:0] idx_byte;
   assign adv_ip = advance(ip_r, cmd.len);
   assign osp_byte = mem[osp_r];
   // Byte at instruction constant plus offset, worked out apart from the datapath.
   assign idx_byte = mem[cmd.operand + ofs_r];

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   sequence s_take(flow_pkg::op_t o);
      accept && cmd.op == o;
   endsequence
   sequence s_fixed_page;
      !(cmd.op inside {flow_pkg::OP_PAGE, flow_pkg::OP_CALL, flow_pkg::OP_INT_ACK,
                       flow_pkg::OP_RET, flow_pkg::OP_INT_RET}) && accept;
   endsequence

   AST_IP_RESET: assert property (disable iff (1'b0) rst |=> ip_r == 14'h0000)
      else $error("Pointer not cleared by reset.");
   AST_SEQ_ADV: assert property (s_take(flow_pkg::OP_SEQ) |=> ip_r == $past(adv_ip))
      else $error("Sequential advance wrong.");
   AST_PAGE_KEEP: assert property (s_fixed_page |=> $stable(ip_r[13:8]))
      else $error("Upper pointer field moved without page advance.");
   AST_PAGE_ADV: assert property (s_take(flow_pkg::OP_PAGE) |=>
      ip_r[13:8] == $past(ip_r[13:8]) + 6'h01)
      else $error("Page advance did not bump the upper field.");
   AST_CALL_CSP: assert property (s_take(flow_pkg::OP_CALL) |=> ##1
      csp_r == $past(csp_r, 2) + 8'h02 && done_r)
      else $error("Call did not raise the stack pointer by two.");
   AST_INT_OFF: assert property (s_take(flow_pkg::OP_INT_ACK) |=> !int_en_r [*2])
      else $error("Interrupts not disabled on entry.");
   AST_RET_FLAGS: assert property (s_take(flow_pkg::OP_RET) |=>
      $stable(carry_r) && $stable(zero_r) [*3])
      else $error("Return changed the flags.");
   AST_INTERRUPT_RETURN_SEQ: assert property (s_take(flow_pkg::OP_INT_RET) |=>
      csp_r == $past(csp_r) - 8'h01 ##1 csp_r == $past(csp_r) - 8'h01 ##1 int_en_r)
      else $error("Interrupt return sequence wrong.");
   AST_PUSH: assert property (s_take(flow_pkg::OP_PUSH) |=>
      osp_r == $past(osp_r) - 8'h01 && osp_byte == $past(acc_r))
      else $error("Push wrote the wrong place.");
   AST_POP: assert property (s_take(flow_pkg::OP_POP) |=>
      acc_r == $past(osp_byte) && osp_r == $past(osp_r) + 8'h01)
      else $error("Pop read or stepped wrongly.");
   AST_LOAD_CSP: assert property (s_take(flow_pkg::OP_LOAD_CSP) |=> csp_r == $past(acc_r))
      else $error("Stack pointer load failed.");
   AST_INDEXED: assert property (s_take(flow_pkg::OP_LOAD_ACC) ##0
      cmd.mode == flow_pkg::AM_INDEXED |=> acc_r == $past(idx_byte))
      else $error("Indexed load used the wrong address.");
endmodule // flow_unit
`default_nettype wire

// ### sim/cmd_source.sv
// Purpose: Command source standing in for program memory and the decoder.
// Assumes: A command is taken on an edge that samples busy_r low.
// Notes: Offers one command, holds it until taken, then waits for done_r.
`timescale 1ns/1ps
`default_nettype none
module cmd_source (
   input wire logic mclk,          // Core clock.
   input wire logic busy_r,        // Unit busy with a frame.
   input wire logic done_r,        // Command finished.
   output var logic cmd_valid,     // Command offered.
   output var flow_pkg::cmd_t cmd  // Decoded command.
);
   // ==========================================================
   // Idle state at time zero.
   initial begin
      cmd_valid = 1'b0;
      cmd = '0;
   end

   // Offer after gap plus one idle cycles; released fields show the inverse so no stale value helps.
   task automatic offer(input flow_pkg::cmd_t c, input int gap, output logic ok);
      int n;
      ok = 1'b0;
      repeat (gap + 1) @(posedge mclk);
      cmd_valid <= 1'b1;
      cmd <= c;
      #1;
      for (n = 0; n < 8 && busy_r !== 1'b0; n++) begin
         @(posedge mclk);
         #1;
      end
      @(posedge mclk);
      cmd_valid <= 1'b0;
      cmd <= flow_pkg::cmd_t'(~c);
      // A one-cycle command shows done_r right after the taking edge, so look there first.
      for (n = 0; n < 8 && ok !== 1'b1; n++) begin
         #1;
         ok = done_r;
         if (ok !== 1'b1) begin
            @(posedge mclk);
         end
      end
   endtask
endmodule // cmd_source
`default_nettype wire

// ### sim/tb_top.sv
// Purpose: Self-checking bench for the program-flow and stack unit.
// Assumes: Expected values are worked out by hand from the reset state.
// Notes: Rows run in order; each starts from the state the previous row left.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   // One row: command, then ip, csp, osp, acc and {carry, zero, int_en} expected after it.
   typedef struct {
      flow_pkg::cmd_t c;
      logic [13:0] ip;
      logic [7:0] csp, osp, acc;
      logic [2:0] fl;
   } row_t;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] rd_addr = 8'h00;
   logic cmd_valid, carry_r, zero_r, int_en_r, busy_r, done_r, ok;
   flow_pkg::cmd_t cmd;
   logic [13:0] ip_r;
   logic [7:0] rd_data_r, csp_r, osp_r, acc_r, ofs_r;
   logic [15:0] mv [9] = '{16'h0040, 16'h0115, 16'h10e8, 16'h135a, 16'hff5a,
      16'h4041, 16'h411b, 16'h4242, 16'h4300};
   int err_total = 0;
   int samples_checked = 0;
   row_t q[$];

   // ==========================================================
   // Clock at 100 MHz and the parts under test.
   always #5 mclk = ~mclk;
   cmd_source src (.mclk(mclk), .busy_r(busy_r), .done_r(done_r), .cmd_valid(cmd_valid),
      .cmd(cmd));
   flow_unit dut (.mclk(mclk), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd),
      .rd_addr(rd_addr), .rd_data_r(rd_data_r), .ip_r(ip_r), .csp_r(csp_r), .osp_r(osp_r),
      .acc_r(acc_r), .ofs_r(ofs_r), .carry_r(carry_r), .zero_r(zero_r),
      .int_en_r(int_en_r), .busy_r(busy_r), .done_r(done_r));

   // ==========================================================
   // Reporting and comparison.
   task automatic print_verdict();
      $display("Checks %0d, mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic chk_word(input string s, input logic [13:0] e, input logic [13:0] g);
      samples_checked++;
      if (g !== e) begin
         $display("Error %s expected %h seen %h", s, e, g);
         err_total++;
      end
   endtask

   task automatic chk_byte(input string s, input logic [7:0] e, input logic [7:0] g);
      chk_word(s, {6'h00, e}, {6'h00, g});
   endtask

   // Offer one command and give up on the run if it never completes.
   task automatic run(input flow_pkg::cmd_t c, input int gap);
      src.offer(c, gap, ok);
      if (ok !== 1'b1) begin
         $display("Error done_r expected 1 seen %b", ok);
         err_total++;
         print_verdict();
      end
   endtask

   task automatic check_reset();
      chk_word("ip", 14'h0000, ip_r);
      chk_byte("csp", 8'h00, csp_r);
      chk_byte("osp", 8'h00, osp_r);
      chk_byte("acc", 8'h00, acc_r);
      chk_byte("ofs", 8'h00, ofs_r);
      chk_byte("rd_data", 8'h00, rd_data_r);
      chk_byte("status", 8'h00, {3'h0, carry_r, zero_r, int_en_r, busy_r, done_r});
   endtask

   function automatic row_t r(input logic [3:0] o, input logic [1:0] ln, input logic [1:0] m,
         input logic [13:0] a, input logic [2:0] f, input logic [13:0] ip,
         input logic [7:0] csp, osp, acc, input logic [2:0] fl);
      r = '{'{flow_pkg::op_t'(o), ln, flow_pkg::amode_t'(m), a[7:0], a, f[2], f[1], f[0]},
         ip, csp, osp, acc, fl};
   endfunction

   // ==========================================================
   // Main sequence: reset, table rows, memory read-back, reset in mid-run.
   initial begin
      repeat (7) @(posedge mclk);
      #1;
      check_reset();
      @(posedge mclk);
      rst <= 1'b0;
      $display("Test reset done");
      q.push_back(r(4'h9,2'h2,2'h0,14'h00e8,3'h0,14'h0002,8'h00,8'h00,8'he8,3'h0));
      q.push_back(r(4'hb,2'h2,2'h1,14'h0010,3'h0,14'h0004,8'h00,8'h00,8'he8,3'h0));
      q.push_back(r(4'ha,2'h2,2'h0,14'h0003,3'h0,14'h0006,8'h00,8'h00,8'he8,3'h0));
      q.push_back(r(4'h9,2'h2,2'h0,14'h005a,3'h0,14'h0008,8'h00,8'h00,8'h5a,3'h0));
      q.push_back(r(4'hb,2'h2,2'h2,14'h0010,3'h0,14'h000a,8'h00,8'h00,8'h5a,3'h0));
      q.push_back(r(4'h9,2'h2,2'h1,14'h0010,3'h0,14'h000c,8'h00,8'h00,8'he8,3'h0));
      q.push_back(r(4'h9,2'h2,2'h2,14'h0010,3'h0,14'h000e,8'h00,8'h00,8'h5a,3'h0));
      q.push_back(r(4'h6,2'h1,2'h0,14'h0000,3'h0,14'h000f,8'h00,8'hff,8'h5a,3'h0));
      q.push_back(r(4'h9,2'h2,2'h0,14'h0000,3'h0,14'h0011,8'h00,8'hff,8'h00,3'h0));
      q.push_back(r(4'h7,2'h1,2'h0,14'h0000,3'h0,14'h0012,8'h00,8'h00,8'h5a,3'h0));
      q.push_back(r(4'h0,2'h1,2'h0,14'h0000,3'h6,14'h0013,8'h00,8'h00,8'h5a,3'h4));
      q.push_back(r(4'h2,2'h2,2'h0,14'h0345,3'h0,14'h0345,8'h02,8'h00,8'h5a,3'h4));
      q.push_back(r(4'h0,2'h1,2'h0,14'h0000,3'h5,14'h0346,8'h02,8'h00,8'h5a,3'h2));
      q.push_back(r(4'h3,2'h1,2'h0,14'h0000,3'h0,14'h0015,8'h00,8'h00,8'h5a,3'h2));
      q.push_back(r(4'h4,2'h1,2'h0,14'h0004,3'h0,14'h0004,8'h02,8'h00,8'h5a,3'h2));
      q.push_back(r(4'h0,2'h1,2'h0,14'h0000,3'h6,14'h0005,8'h02,8'h00,8'h5a,3'h4));
      q.push_back(r(4'h5,2'h1,2'h0,14'h0000,3'h0,14'h0015,8'h00,8'h00,8'h5a,3'h3));
      q.push_back(r(4'h1,2'h1,2'h0,14'h0000,3'h0,14'h0116,8'h00,8'h00,8'h5a,3'h3));
      q.push_back(r(4'h9,2'h2,2'h0,14'h0040,3'h0,14'h0118,8'h00,8'h00,8'h40,3'h3));
      q.push_back(r(4'h8,2'h1,2'h0,14'h0000,3'h0,14'h0119,8'h40,8'h00,8'h40,3'h3));
      q.push_back(r(4'h2,2'h2,2'h0,14'h02fe,3'h0,14'h02fe,8'h42,8'h00,8'h40,3'h3));
      q.push_back(r(4'h0,2'h2,2'h0,14'h0000,3'h0,14'h0200,8'h42,8'h00,8'h40,3'h3));
      q.push_back(r(4'h4,2'h1,2'h0,14'h0008,3'h0,14'h0008,8'h44,8'h00,8'h40,3'h2));
      // Sequential code leaves its page only through the page advance row.
      foreach (q[i]) begin
         run(q[i].c, i % 3);
         chk_word("ip", q[i].ip, ip_r);
         chk_byte("csp", q[i].csp, csp_r);
         chk_byte("osp", q[i].osp, osp_r);
         chk_byte("acc", q[i].acc, acc_r);
         chk_byte("flags", {5'h00, q[i].fl}, {5'h00, carry_r, zero_r, int_en_r});
         chk_byte("busy", 8'h00, {7'h00, busy_r});
      end
      chk_byte("ofs", 8'h03, ofs_r);
      $display("Test rows done");
      foreach (mv[i]) begin
         @(posedge mclk);
         rd_addr <= mv[i][15:8];
         @(posedge mclk);
         #1;
         chk_byte("mem", mv[i][7:0], rd_data_r);
      end
      $display("Test memory done");
      @(posedge mclk);
      rst <= 1'b1;
      repeat (8) @(posedge mclk);
      #1;
      check_reset();
      @(posedge mclk);
      rst <= 1'b0;
      // After the second reset a lone push from zero shows the operand stack pointer wrap to 0xFF.
      run(q[7].c, 0);
      chk_byte("osp", 8'hff, osp_r);
      chk_word("ip", 14'h0001, ip_r);
      $display("Test second reset done");
      print_verdict();
   end
endmodule // tb_top
`default_nettype wire
